/* rtl/lane_ram.v */
// Purpose: word store built from four byte lanes
// Assumes: one write port with lane mask, two asynchronous read ports
// Notes: depth set per instance, lanes let single bytes be written
`timescale 1ns/1ns
module lane_ram #(
  parameter DEPTH = 1024,
  parameter AW = 10
) (
  input wire clock_in,             // block clock
  input wire we_in,                // write strobe
  input wire [3:0] lane_in,        // byte lanes to write
  input wire [AW-1:0] waddr_in,    // write word index
  input wire [31:0] wdata_in,      // write data
  input wire [AW-1:0] raddr_a_in,  // read index, port a
  output wire [31:0] rdata_a_out,  // read data, port a
  input wire [AW-1:0] raddr_b_in,  // read index, port b
  output wire [31:0] rdata_b_out   // read data, port b
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_lane
      reg [7:0] mem [0:DEPTH-1];
      always @(posedge clock_in)
      begin
        if (we_in && lane_in[i])
          mem[waddr_in] <= wdata_in[8*i+7:8*i];
      end
      assign rdata_a_out[8*i+7:8*i] = mem[raddr_a_in];
      assign rdata_b_out[8*i+7:8*i] = mem[raddr_b_in];
    end
  endgenerate
endmodule // lane_ram

/* rtl/ptp_buf_defs.vh */
// Purpose: shared constants of the ptp frame buffer block
// Assumes: byte addresses on the register port, 32-bit data words
// Notes: definitions only
`ifndef PTP_BUF_DEFS_VH
`define PTP_BUF_DEFS_VH
// build option: 1 when the bridging option is present
`define AVB_OPTION 1'b1
`define ADDR_W 17
// region decode on byte address
`define RX_REGION 5'h10
`define TX_REGION 6'h22
`define REG_TX_CTRL 17'h12000
`define REG_RX_CTRL 17'h12004
`define REG_RESERVED 17'h12008
`define REG_RX_RDPTR 17'h12014
// store geometry: sizes and TS_WORD in 32-bit words, frame offsets and lengths in bytes
`define RX_WORDS 1024
`define TX_WORDS 512
`define SLOT_WORDS 64
`define TS_WORD 6'h3F
`define TX_FRAME_OFS 8'h08
`define TX_MAX_LEN 8'hF4
`define RX_LAST_BYTE 8'hFB
// control register fields
`define TXC_SLOT_LSB 16
`define TXC_PEND_LSB 8
`define RXC_SLOT_LSB 8
`define RXC_FLUSH_BIT 0
// default transmit frame contents
`define DEF_LEN 8'h44
`define DEF_TYPE_HI 8'h88
`define DEF_TYPE_LO 8'hF7
`define DEF_VERSION 8'h02
`define INIT_LAST 9'h1FF
`endif

/* rtl/ptp_frame_buffers.v */
// Purpose: receive and transmit ptp frame stores with their control registers
// Assumes: mac frame path and arbiter run on clock_in; byte stream one byte a cycle
// Notes: register port reads answer one cycle after the read strobe
//
// Summary of operation
// R1 - stores and their control exist only when the bridging option is built.
// R2 - receive store is 4K bytes, all readable by software.
// R3 - receive store is sixteen 256-byte slots, slot n at base plus n*0x100.
// R4 - after a frame is stored, write pointer moves to the next slot.
// R5 - received frame is written from the slot base onward.
// R6 - receive timestamp goes into the top four bytes of the slot.
// R7 - transmit store is 2K bytes, eight 256-byte slots, software accessible.
// R8 - after reset slots 0 to 6 hold default frames, slot 7 none.
// R9 - first byte of a transmit slot gives the byte count sent.
// R10 - transmit frame bytes start at the eighth address of the slot.
// R11 - transmit timestamp goes into the top four bytes of the slot.
// R12 - transmit control shows slot number of last transmitted frame.
// R13 - pending bits stay set from request until the frame has gone.
// R14 - writing 1 to a request bit asks the arbiter; bits read zero.
// R15 - transmit done flag set per frame, cleared by any control access.
// R16 - control registers decode at 0x12000, 0x12004; 0x12008 reserved.
// R17 - receive control shows slot number of last received frame.
// R18 - flush bit sets write pointer to read pointer, reads zero.
// R19 - receive done flag set per frame, cleared by any control access.
// R20 - receive write pointer wraps from slot 15 to slot 0.
// R21 - reserved transmit control bits read zero, writes ignored.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "ptp_buf_defs.vh"
module ptp_frame_buffers (
  input wire clock_in,                     // 20 MHz block clock
  input wire rst_in,                       // asynchronous reset, active high
  input wire [`ADDR_W-1:0] addr_in,        // register byte address
  input wire [31:0] wr_data_in,            // register write data
  input wire wr_in,                        // write strobe
  input wire rd_in,                        // read strobe
  output reg [31:0] rd_data_out,           // read data, cycle after strobe
  input wire rx_valid_in,                  // receive byte valid
  input wire [7:0] rx_data_in,             // receive byte
  input wire rx_last_in,                   // last byte of frame
  input wire rx_ts_valid_in,               // frame good, timestamp valid
  input wire [31:0] rx_ts_in,              // receive timestamp
  output reg tx_req_out,                   // request to arbiter
  input wire tx_grant_in,                  // arbiter grant pulse
  output reg tx_valid_out,                 // transmit byte valid
  output reg [7:0] tx_data_out,            // transmit byte
  output reg tx_last_out,                  // last transmit byte
  input wire tx_ready_in,                  // mac takes transmit byte
  input wire tx_ts_valid_in,               // frame sent, timestamp valid
  input wire [31:0] tx_ts_in,              // transmit timestamp
  output reg rx_done_irq_out,              // receive done flag
  output reg tx_done_irq_out               // transmit done flag
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_REQ = 5'h02;
  localparam [4:0] ST_LOAD = 5'h04;
  localparam [4:0] ST_SEND = 5'h08;
  localparam [4:0] ST_STAMP = 5'h10;

  //////////////////////////////////////////////////////////////////////
  // address decode
  wire rx_hit = `AVB_OPTION && (addr_in[16:12] == `RX_REGION); // [R1] [R2] [R3]
  wire tx_hit = `AVB_OPTION && (addr_in[16:11] == `TX_REGION); // [R1] [R7]
  wire txc_hit = `AVB_OPTION && (addr_in == `REG_TX_CTRL); // [R16]
  wire rxc_hit = `AVB_OPTION && (addr_in == `REG_RX_CTRL); // [R16]
  wire rdp_hit = `AVB_OPTION && (addr_in == `REG_RX_RDPTR);

  //////////////////////////////////////////////////////////////////////
  // state
  reg [3:0] wr_ptr_q;
  reg [3:0] rd_ptr_q;
  reg [3:0] last_rx_q;
  reg [7:0] rx_idx_q;
  reg [7:0] pend_q;
  reg [2:0] last_tx_q;
  reg [2:0] slot_q;
  reg [7:0] len_q;
  reg [7:0] tx_idx_q;
  reg [4:0] state_q;
  reg init_q;
  reg [8:0] init_cnt_q;

  //////////////////////////////////////////////////////////////////////
  // receive store
  wire [9:0] rx_waddr;
  wire [3:0] rx_lane;
  wire [31:0] rx_wdata;
  wire rx_byte_we = rx_valid_in && (rx_idx_q <= `RX_LAST_BYTE) && `AVB_OPTION;
  wire [31:0] rx_rdata;
  // timestamp write takes the port; it never meets a data byte in practice
  assign rx_waddr = rx_ts_valid_in ? {wr_ptr_q, `TS_WORD} // [R6]
                                   : {wr_ptr_q, rx_idx_q[7:2]}; // [R5]
  assign rx_lane = rx_ts_valid_in ? 4'hF : (4'h1 << rx_idx_q[1:0]);
  assign rx_wdata = rx_ts_valid_in ? rx_ts_in : {4{rx_data_in}};

  lane_ram #(
    .DEPTH(`RX_WORDS),
    .AW(10)
  ) u_rx_ram (
    .clock_in(clock_in),
    .we_in(rx_byte_we || (rx_ts_valid_in && `AVB_OPTION)),
    .lane_in(rx_lane),
    .waddr_in(rx_waddr),
    .wdata_in(rx_wdata),
    .raddr_a_in(addr_in[11:2]),
    .rdata_a_out(rx_rdata),
    .raddr_b_in(10'h000),
    .rdata_b_out()
  );

  //////////////////////////////////////////////////////////////////////
  // transmit store
  wire [31:0] tpl_data;
  wire [31:0] tx_rdata_bus;
  wire [31:0] tx_rdata_mac;
  wire [7:0] tx_ofs = `TX_FRAME_OFS + tx_idx_q; // [R10]
  wire [8:0] tx_mac_addr;
  wire stamp_we = state_q[4] && tx_ts_valid_in;
  wire bus_tx_we = wr_in && tx_hit && !init_q;
  reg tx_we;
  reg [8:0] tx_waddr;
  reg [31:0] tx_wdata;

  // length byte while waiting for grant, frame bytes afterwards
  assign tx_mac_addr = state_q[1] ? {slot_q, 6'h00} : {slot_q, tx_ofs[7:2]}; // [R9]

  ptp_template u_tpl (
    .word_in(init_cnt_q),
    .data_out(tpl_data)
  );

  // loader first, then timestamp; a bus write meeting a timestamp is lost
  always @*
  begin
    tx_we = 1'b0;
    tx_waddr = addr_in[10:2];
    tx_wdata = wr_data_in;
    if (init_q)
    begin
      tx_we = 1'b1; // [R8]
      tx_waddr = init_cnt_q;
      tx_wdata = tpl_data;
    end
    else if (stamp_we)
    begin
      tx_we = 1'b1; // [R11]
      tx_waddr = {slot_q, `TS_WORD};
      tx_wdata = tx_ts_in;
    end
    else if (bus_tx_we)
    begin
      tx_we = 1'b1; // [R7]
    end
  end

  lane_ram #(
    .DEPTH(`TX_WORDS),
    .AW(9)
  ) u_tx_ram (
    .clock_in(clock_in),
    .we_in(tx_we),
    .lane_in(4'hF),
    .waddr_in(tx_waddr),
    .wdata_in(tx_wdata),
    .raddr_a_in(addr_in[10:2]),
    .rdata_a_out(tx_rdata_bus),
    .raddr_b_in(tx_mac_addr),
    .rdata_b_out(tx_rdata_mac)
  );

  // reset-time loader fills the defaults; transmit waits until it is done
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      init_q <= 1'b1;
      init_cnt_q <= 9'h000;
    end
    else if (init_q)
    begin
      init_cnt_q <= init_cnt_q + 9'h001;
      if (init_cnt_q == `INIT_LAST)
        init_q <= 1'b0; // [R8]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive pointer and flags
  wire rx_flush = wr_in && rxc_hit && wr_data_in[`RXC_FLUSH_BIT];
  wire rxc_touch = (wr_in || rd_in) && rxc_hit;
  wire txc_touch = (wr_in || rd_in) && txc_hit;

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      last_rx_q <= 4'h0;
      rx_idx_q <= 8'h00;
      rx_done_irq_out <= 1'b0;
    end
    else
    begin
      if (wr_in && rdp_hit)
        rd_ptr_q <= wr_data_in[3:0];
      if (rx_flush)
      begin
        wr_ptr_q <= rd_ptr_q; // [R18]
        rx_idx_q <= 8'h00;
      end
      else if (rx_ts_valid_in && `AVB_OPTION)
      begin
        last_rx_q <= wr_ptr_q; // [R17]
        wr_ptr_q <= wr_ptr_q + 4'h1; // [R4] [R20]
      end
      if (!rx_flush && rx_valid_in)
      begin
        if (rx_last_in)
          rx_idx_q <= 8'h00;
        else if (rx_idx_q != 8'hFF)
          rx_idx_q <= rx_idx_q + 8'h01;
      end
      // a completion in the clearing cycle keeps the flag set
      if (rx_ts_valid_in && `AVB_OPTION)
        rx_done_irq_out <= 1'b1; // [R19]
      else if (rxc_touch)
        rx_done_irq_out <= 1'b0; // [R19]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transmit request and send sequence
  wire [7:0] req_set = (wr_in && txc_hit) ? wr_data_in[7:0] : 8'h00; // [R14]
  reg [2:0] pick;
  integer k;

  // lowest pending slot goes first
  always @*
  begin
    pick = 3'h0;
    for (k = 7; k >= 0; k = k - 1)
    begin
      if (pend_q[k])
        pick = k[2:0];
    end
  end

  wire [7:0] len_raw = tx_rdata_mac[7:0];
  wire [31:0] byte_shift = tx_rdata_mac >> {tx_ofs[1:0], 3'b000};
  wire [7:0] byte_sel = byte_shift[7:0];
  // an empty slot is retired at grant, a sent one at its timestamp
  wire zero_len = state_q[1] && tx_grant_in && (len_raw == 8'h00); // [R9]
  wire [7:0] pend_clr = (zero_len || stamp_we) ? (8'h01 << slot_q) : 8'h00; // [R13]

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      pend_q <= 8'h00;
      slot_q <= 3'h0;
      len_q <= 8'h00;
      tx_idx_q <= 8'h00;
      last_tx_q <= 3'h0;
      tx_req_out <= 1'b0;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_last_out <= 1'b0;
      tx_done_irq_out <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (pend_q != 8'h00 && !init_q)
          begin
            slot_q <= pick;
            tx_req_out <= 1'b1; // [R14]
            state_q <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          if (tx_grant_in)
          begin
            tx_req_out <= 1'b0;
            tx_idx_q <= 8'h00;
            len_q <= (len_raw > `TX_MAX_LEN) ? `TX_MAX_LEN : len_raw; // [R9]
            if (len_raw == 8'h00)
              state_q <= ST_IDLE;
            else
              state_q <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          tx_data_out <= byte_sel; // [R10]
          tx_valid_out <= 1'b1;
          tx_last_out <= (tx_idx_q + 8'h01 == len_q); // [R9]
          state_q <= ST_SEND;
        end
        ST_SEND:
        begin
          if (tx_ready_in)
          begin
            tx_valid_out <= 1'b0;
            tx_last_out <= 1'b0;
            tx_idx_q <= tx_idx_q + 8'h01;
            state_q <= tx_last_out ? ST_STAMP : ST_LOAD;
          end
        end
        ST_STAMP:
        begin
          if (tx_ts_valid_in)
          begin
            last_tx_q <= slot_q; // [R12]
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          tx_req_out <= 1'b0;
          tx_valid_out <= 1'b0;
        end
      endcase
      // a new request for the finishing slot survives the clear
      pend_q <= (pend_q & ~pend_clr) | (req_set & {8{`AVB_OPTION}}); // [R13]
      if (stamp_we)
        tx_done_irq_out <= 1'b1; // [R15]
      else if (txc_touch)
        tx_done_irq_out <= 1'b0; // [R15]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register read
  reg [31:0] rd_d;

  always @*
  begin
    rd_d = 32'h0000_0000;
    if (rx_hit)
      rd_d = rx_rdata; // [R2]
    else if (tx_hit)
      rd_d = tx_rdata_bus; // [R7]
    else if (txc_hit)
    begin
      rd_d[`TXC_SLOT_LSB+2:`TXC_SLOT_LSB] = last_tx_q; // [R12] [R21]
      rd_d[`TXC_PEND_LSB+7:`TXC_PEND_LSB] = pend_q; // [R13]
    end
    else if (rxc_hit)
      rd_d[`RXC_SLOT_LSB+3:`RXC_SLOT_LSB] = last_rx_q; // [R17]
    else if (rdp_hit)
      rd_d[3:0] = rd_ptr_q;
  end

  // answer stands only in the cycle after the strobe
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      rd_data_out <= 32'h0000_0000;
    else if (rd_in)
      rd_data_out <= rd_d;
    else
      rd_data_out <= 32'h0000_0000;
  end
endmodule // ptp_frame_buffers

/* rtl/ptp_template.v */
// Purpose: default contents of the transmit frame slots
// Assumes: word index into the 2K transmit store
// Notes: pure logic, read word by word by the reset-time loader
`timescale 1ns/1ns
`include "ptp_buf_defs.vh"
module ptp_template (
  input wire [8:0] word_in,   // word index within transmit store
  output wire [31:0] data_out // default word
);
  // message type code per slot; slot 7 has no default frame
  function [7:0] def_byte;
    input [2:0] slot;
    input [7:0] ofs;
    reg [7:0] mtype;
    begin
      case (slot)
        3'h0: mtype = 8'h00;
        3'h1: mtype = 8'h08;
        3'h2: mtype = 8'h02;
        3'h3: mtype = 8'h03;
        3'h4: mtype = 8'h0A;
        3'h5: mtype = 8'h0B;
        default: mtype = 8'h0C;
      endcase
      case (ofs)
        8'h00: def_byte = `DEF_LEN;
        8'h08: def_byte = 8'h01;
        8'h09: def_byte = 8'h80;
        8'h0A: def_byte = 8'hC2;
        8'h0D: def_byte = 8'h0E;
        8'h14: def_byte = `DEF_TYPE_HI;
        8'h15: def_byte = `DEF_TYPE_LO;
        8'h16: def_byte = mtype;
        8'h17: def_byte = `DEF_VERSION;
        default: def_byte = 8'h00;
      endcase
      if (slot == 3'h7)
        def_byte = 8'h00;
    end
  endfunction
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_byte
      localparam [1:0] LANE = i;
      assign data_out[8*i+7:8*i] = def_byte(word_in[8:6], {word_in[5:0], LANE});
    end
  endgenerate
endmodule // ptp_template

/* testbench/mac_side_model.sv */
// Purpose: mac frame path and arbiter facing the ptp buffers
// Assumes: same clock as the block
// Notes: grants three cycles after the request, ready two cycles of four
`timescale 1ns/1ns
module mac_side_model (
  input wire clock_in, // clock
  input wire rst_in, // reset
  input wire tx_req_in, // request
  output reg tx_grant_out, // grant pulse
  input wire tx_valid_in, // byte valid
  input wire tx_last_in, // last byte
  output reg tx_ready_out, // byte taken
  output reg tx_ts_valid_out, // frame sent
  output wire [31:0] tx_ts_out, // tx timestamp
  output reg rx_valid_out = 1'b0, // rx byte valid
  output reg [7:0] rx_data_out = 8'h0, // rx byte
  output reg rx_last_out = 1'b0, // last rx byte
  output reg rx_ts_valid_out = 1'b0, // frame good
  output wire [31:0] rx_ts_out // rx timestamp
);
  reg [1:0] wait_q;
  reg [1:0] stall_q;
  reg [2:0] dly_q;
  reg [31:0] ts_q;
  reg [31:0] rts_q = 32'h0;
  // outside the pulse the timestamps show a wrong value, not a stale one
  assign tx_ts_out = tx_ts_valid_out ? ts_q : ~ts_q;
  assign rx_ts_out = rx_ts_valid_out ? rts_q : ~rts_q;
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wait_q <= 2'h0;
      stall_q <= 2'h0;
      dly_q <= 3'h0;
      ts_q <= 32'h7E000001;
      tx_grant_out <= 1'b0;
      tx_ready_out <= 1'b0;
      tx_ts_valid_out <= 1'b0;
    end
    else
    begin
      stall_q <= stall_q + 2'h1;
      tx_ready_out <= stall_q[1];
      wait_q <= tx_req_in ? wait_q + {1'b0, wait_q != 2'h3} : 2'h0;
      tx_grant_out <= tx_req_in && wait_q == 2'h2;
      tx_ts_valid_out <= dly_q == 3'h3;
      if (tx_valid_in && tx_ready_out && tx_last_in)
        dly_q <= 3'h1;
      else if (dly_q != 3'h0)
        dly_q <= dly_q + 3'h1;
      if (tx_ts_valid_out)
        ts_q <= ts_q + 32'h1;
    end
  end
  task send_rx(input [31:0] word, input [31:0] ts);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        @(posedge clock_in);
        rx_valid_out <= 1'b1;
        rx_data_out <= word[8*i +: 8];
        rx_last_out <= i == 3;
      end
      @(posedge clock_in);
      rx_valid_out <= 1'b0;
      rx_last_out <= 1'b0;
      rx_data_out <= ~word[31:24];
      rts_q <= ts;
      rx_ts_valid_out <= 1'b1;
      @(posedge clock_in);
      rx_ts_valid_out <= 1'b0;
    end
  endtask
endmodule // mac_side_model

/* testbench/ptp_frame_buffers_checker.sv */
// Purpose: port-level assertions for the ptp frame buffers
// Assumes: single clock, reset active high
// Notes: bound into every instance of the block
`timescale 1ns/1ns
`include "ptp_buf_defs.vh"
module ptp_frame_buffers_checker (
  input wire clock_in, // clock
  input wire rst_in, // reset
  input wire [`ADDR_W-1:0] addr_in, // address
  input wire wr_in, // write strobe
  input wire rd_in, // read strobe
  input wire [31:0] rd_data_out, // read data
  input wire rx_ts_valid_in, // rx complete
  input wire tx_ts_valid_in, // tx complete
  input wire tx_req_out, // request
  input wire tx_grant_in, // grant
  input wire tx_valid_out, // byte valid
  input wire tx_ready_in, // byte taken
  input wire [7:0] tx_data_out, // byte
  input wire tx_last_out, // last byte
  input wire rx_done_irq_out, // rx flag
  input wire tx_done_irq_out // tx flag
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  wire acc = rd_in | wr_in;
  chk_rd_idle_zero: assert property (!rd_in |=> rd_data_out == 32'h0)
    else $error("read data not zero while idle");
  chk_resv_zero: assert property (rd_in && addr_in == `REG_RESERVED |=> rd_data_out == 32'h0)
    else $error("reserved word not zero");
  chk_txc_fields: assert property (rd_in && addr_in == `REG_TX_CTRL
    |=> rd_data_out[31:19] == 13'h0 && rd_data_out[7:0] == 8'h0)
    else $error("tx control reserved or request bits set");
  chk_rxc_fields: assert property (rd_in && addr_in == `REG_RX_CTRL
    |=> rd_data_out[31:12] == 20'h0 && rd_data_out[7:0] == 8'h0)
    else $error("rx control reserved or flush bits set");
  chk_txirq_clear: assert property (acc && addr_in == `REG_TX_CTRL && !tx_ts_valid_in
    |=> !tx_done_irq_out)
    else $error("tx flag not cleared by access");
  chk_rxirq_clear: assert property (acc && addr_in == `REG_RX_CTRL && !rx_ts_valid_in
    |=> !rx_done_irq_out)
    else $error("rx flag not cleared by access");
  chk_rxirq_set: assert property (rx_ts_valid_in |=> rx_done_irq_out)
    else $error("rx flag not raised");
  chk_txirq_set: assert property (tx_ts_valid_in |=> tx_done_irq_out)
    else $error("tx flag not raised");
  chk_req_hold: assert property (tx_req_out && !tx_grant_in |=> tx_req_out)
    else $error("request dropped before grant");
  chk_req_drop: assert property (tx_req_out && tx_grant_in |=> !tx_req_out)
    else $error("request kept after grant");
  chk_byte_hold: assert property (tx_valid_out && !tx_ready_in
    |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
    else $error("tx byte changed while stalled");
  cover property (rd_in && addr_in == `REG_RESERVED);
  cover property (tx_valid_out && tx_ready_in && tx_last_out);
  cover property (rx_ts_valid_in ##2 rx_done_irq_out);
endmodule // ptp_frame_buffers_checker
bind ptp_frame_buffers ptp_frame_buffers_checker chk_u (
  .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .rx_ts_valid_in(rx_ts_valid_in),
  .tx_ts_valid_in(tx_ts_valid_in), .tx_req_out(tx_req_out), .tx_grant_in(tx_grant_in),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .tx_data_out(tx_data_out),
  .tx_last_out(tx_last_out), .rx_done_irq_out(rx_done_irq_out),
  .tx_done_irq_out(tx_done_irq_out));

/* testbench/ptp_frame_buffers_tb.sv */
// Purpose: self-checking bench for the ptp frame buffers
// Assumes: 20 MHz clock, partner model on the mac side
// Notes: expected reads and bytes queued by the driver, checked by monitors
`timescale 1ns/1ns
`include "ptp_buf_defs.vh"
module ptp_frame_buffers_tb;
  reg clock_in = 1'b0;
  reg rst_in = 1'b1;
  reg [`ADDR_W-1:0] addr = 17'h0;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rd_seen = 1'b0;
  wire [31:0] rdata, rxts, txts;
  wire [7:0] rxd, txd;
  wire rxv, rxl, rxt, req, gnt, txv, txl, rdy, txt, rxirq, txirq;
  integer n_errors = 0;
  integer n_checks = 0;
  integer k;
  reg [63:0] rdq[$];
  reg [8:0] txq[$];
  reg [63:0] e;
  reg [15:0] lf = 16'h001B;
  reg [31:0] w, t;
  reg [16:0] a;
  always #25 clock_in = ~clock_in;
  ptp_frame_buffers dut_u (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .rx_valid_in(rxv),
    .rx_data_in(rxd), .rx_last_in(rxl), .rx_ts_valid_in(rxt), .rx_ts_in(rxts),
    .tx_req_out(req), .tx_grant_in(gnt), .tx_valid_out(txv), .tx_data_out(txd),
    .tx_last_out(txl), .tx_ready_in(rdy), .tx_ts_valid_in(txt), .tx_ts_in(txts),
    .rx_done_irq_out(rxirq), .tx_done_irq_out(txirq));
  mac_side_model mac_u (.clock_in(clock_in), .rst_in(rst_in), .tx_req_in(req),
    .tx_grant_out(gnt), .tx_valid_in(txv), .tx_last_in(txl), .tx_ready_out(rdy),
    .tx_ts_valid_out(txt), .tx_ts_out(txts), .rx_valid_out(rxv), .rx_data_out(rxd),
    .rx_last_out(rxl), .rx_ts_valid_out(rxt), .rx_ts_out(rxts));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task fail(input [8*20-1:0] msg);
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t %0s", $time, msg);
    end
  endtask
  task cmp_word(input [31:0] got, input [31:0] exp, input [31:0] m);
    begin
      n_checks = n_checks + 1;
      if ((got & m) !== (exp & m))
        fail("read data mismatch");
    end
  endtask
  task cmp_byte(input [8:0] got, input [8:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
        fail("tx byte mismatch");
    end
  endtask
  task cmp_bit(input got, input exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
        fail("flag mismatch");
    end
  endtask
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task rnd(output [31:0] v);
    begin
      lf = lfsr(lf);
      v[15:0] = lf;
      lf = lfsr(lf);
      v[31:16] = lf;
    end
  endtask
  task wr_reg(input [16:0] ad, input [31:0] d);
    begin
      @(posedge clock_in);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [16:0] ad, input [31:0] x, input [31:0] m);
    begin
      @(posedge clock_in);
      addr <= ad;
      rd <= 1'b1;
      rdq.push_back({m, x});
      @(posedge clock_in);
      rd <= 1'b0;
    end
  endtask
  // let the strobe edge land before looking at a flag
  task settle;
    begin
      @(posedge clock_in);
      #5;
    end
  endtask
  task wait_flag(input sel);
    integer i;
    begin
      for (i = 0; i < 2000 && (sel ? txirq : rxirq) !== 1'b1; i = i + 1)
        @(posedge clock_in);
      #5;
      cmp_bit(sel ? txirq : rxirq, 1'b1);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_in)
  begin
    if (rd_seen)
    begin
      e = rdq.pop_front();
      cmp_word(rdata, e[31:0], e[63:32]);
    end
    rd_seen <= rd;
    if (txv && rdy)
      cmp_byte({txl, txd}, txq.size() > 0 ? txq.pop_front() : 9'h1FF);
  end
  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    // the loader owns the transmit store for 512 cycles
    repeat (520) @(posedge clock_in);
    wr_reg(`REG_RESERVED, 32'hFFFFFFFF);
    wr_reg(`REG_TX_CTRL, 32'hFFFFFF00);
    rd_reg(`REG_TX_CTRL, 32'h0, 32'hFFFFFFFF);
    rd_reg(`REG_RX_CTRL, 32'h0, 32'hFFFFFFFF);
    rd_reg(`REG_RESERVED, 32'h0, 32'hFFFFFFFF);
    rd_reg(17'h12010, 32'h0, 32'hFFFFFFFF);
    for (k = 0; k < 7; k = k + 1)
    begin
      a = 17'h11000 + {k[3:0], 8'h00};
      rd_reg(a, {24'h0, `DEF_LEN}, 32'hFF);
      rd_reg(a + 17'h8, 32'h00C28001, 32'hFFFFFFFF);
    end
    $display("test reset done");
    for (k = 0; k < 17; k = k + 1)
    begin
      rnd(w);
      rnd(t);
      mac_u.send_rx(w, t);
      wait_flag(1'b0);
      a = 17'h10000 + {k[3:0], 8'h00};
      wr_reg(a, ~w);
      rd_reg(`REG_RX_CTRL, {20'h0, k[3:0], 8'h00}, 32'hFFFFFFFF);
      rd_reg(a, w, 32'hFFFFFFFF);
      rd_reg(a + 17'hFC, t, 32'hFFFFFFFF);
      settle;
      cmp_bit(rxirq, 1'b0);
    end
    wr_reg(`REG_RX_RDPTR, 32'h5);
    rd_reg(`REG_RX_RDPTR, 32'h5, 32'hFFFFFFFF);
    wr_reg(`REG_RX_CTRL, 32'h1);
    rd_reg(`REG_RX_CTRL, 32'h0, 32'hFFFFFFFF);
    mac_u.send_rx(w, t);
    wait_flag(1'b0);
    rd_reg(`REG_RX_CTRL, 32'h500, 32'hFFFFFFFF);
    rd_reg(17'h10500, w, 32'hFFFFFFFF);
    $display("test receive done");
    wr_reg(17'h11700, 32'h5);
    wr_reg(17'h11708, 32'h44332211);
    wr_reg(17'h1170C, 32'h55);
    wr_reg(17'h11000, 32'h6);
    txq = '{9'h001, 9'h080, 9'h0C2, 9'h000, 9'h000, 9'h10E,
      9'h011, 9'h022, 9'h033, 9'h044, 9'h155};
    wr_reg(`REG_TX_CTRL, 32'h81);
    rd_reg(`REG_TX_CTRL, 32'h8100, 32'hFFFFFFFF);
    wait_flag(1'b1);
    rd_reg(`REG_TX_CTRL, 32'h8000, 32'hFFFFFFFF);
    settle;
    wait_flag(1'b1);
    rd_reg(`REG_TX_CTRL, 32'h70000, 32'hFFFFFFFF);
    rd_reg(17'h110FC, 32'h7E000001, 32'hFFFFFFFF);
    rd_reg(17'h117FC, 32'h7E000002, 32'hFFFFFFFF);
    // a zero length slot is retired at grant and sends nothing
    wr_reg(17'h11100, 32'h0);
    wr_reg(`REG_TX_CTRL, 32'h2);
    repeat (10) @(posedge clock_in);
    rd_reg(`REG_TX_CTRL, 32'h70000, 32'hFFFFFFFF);
    settle;
    cmp_bit(txirq, 1'b0);
    cmp_bit(txq.size() == 0, 1'b1);
    $display("test transmit done");
    complete_run;
  end
  initial
  begin
    #(20000 * 50);
    fail("watchdog expired");
    complete_run;
  end
endmodule // ptp_frame_buffers_tb
